/* core/fdf_pkg.sv */
// package of the fault detection and filtering block: register map,
// field positions, reset values and timing constants.
// assumes a 32-bit classic wishbone slave port and a 10 MHz core clock.
package fdf_pkg;

  // register byte offsets
  localparam logic [7:0] FDF_SETUP_OFS   = 8'h00;
  localparam logic [7:0] FDF_STATUS_OFS  = 8'h04;
  localparam logic [7:0] FDF_OV_OFS      = 8'h08;
  localparam logic [7:0] FDF_UV_OFS      = 8'h0C;
  localparam logic [7:0] FDF_OT_OFS      = 8'h10;
  localparam logic [7:0] FDF_OW_OFS      = 8'h14;
  localparam logic [7:0] FDF_CMD_OFS     = 8'h18;
  localparam logic [7:0] FDF_IRQ_STS_OFS = 8'h1C;
  localparam logic [7:0] FDF_IRQ_CLR_OFS = 8'h20;
  localparam logic [7:0] FDF_IRQ_EN_OFS  = 8'h24;

  // setup register fields
  localparam int          FDF_SETUP_W      = 13;
  localparam logic [12:0] FDF_SETUP_RST    = 13'h0000;
  localparam int          FDF_PERIOD_LSB   = 0;
  localparam int          FDF_WIRE_SEL_BIT = 4;
  localparam int          FDF_CONFIRM_LSB  = 5;
  localparam int          FDF_TEMP_EN_LSB  = 8;
  localparam logic [3:0]  FDF_PERIOD_MAX   = 4'hC;

  // fault status bits
  localparam int FDF_ST_OV   = 0;
  localparam int FDF_ST_UV   = 1;
  localparam int FDF_ST_OT   = 2;
  localparam int FDF_ST_OW   = 3;
  localparam int FDF_ST_PACK = 4;
  localparam int FDF_ST_GND  = 5;
  localparam int FDF_ST_RAIL = 6;
  localparam int FDF_ST_CLK  = 7;
  localparam int FDF_ST_W    = 8;

  // command register bits
  localparam int FDF_CMD_VSCAN   = 0;
  localparam int FDF_CMD_MEASURE = 1;
  localparam int FDF_CMD_TSCAN   = 2;
  localparam int FDF_CMD_WSCAN   = 3;
  localparam int FDF_CMD_CONT    = 4;

  // interrupt bits: validated fault or rail or clock fault, scan sample taken
  localparam int FDF_IRQ_FAULT  = 0;
  localparam int FDF_IRQ_SAMPLE = 1;
  localparam int FDF_IRQ_W      = 2;

  // timing: shortest repeat interval and core clock
  localparam int FDF_BASE_INTERVAL_MS = 16;
  localparam int FDF_CLK_HZ           = 10_000_000;
  localparam int FDF_BASE_CYCLES      = FDF_BASE_INTERVAL_MS * (FDF_CLK_HZ / 1000);

endpackage

/* core/fdf_top.sv */
// fault detection and filtering: supply and clock monitors, scan-driven
// sampling of cell limit results, confirmation filters and fault status.
// assumes comparator results arrive asynchronously on pins and software
// uses a classic wishbone master on clk_i.
//
// Functional notes
// R01: supply rail excursion sets fault immediately
// R02: oscillator deviation sets clock fault immediately
// R03: per-cell fault bits OR into summaries
// R04: pack-open and ground-open single status bits
// R05: limit results updated only by scans
// R06: voltage scan samples ov, uv, pack, ground
// R07: cell measure samples ov and uv
// R08: continuous scan re-samples every interval
// R09: host repeats other scan commands itself
// R10: fault valid after unbroken positive run
// R11: confirm code selects run of 2^code
// R12: repeat code selects 16 ms doubling interval
// R13: independent filter per input, pack, ground
// R14: negative sample restarts that filter
// R15: status change clears all filters; the code clears them only when a host write changes the status
// R16: host rewrites status to clear faults
// R17: validated fault raises the alarm output
// R18: fault bits stay set until host writes
`timescale 1ns/1ps
`default_nettype none
module fdf_top
  import fdf_pkg::*;
#(
  parameter int          N_CELLS     = 12,
  parameter int unsigned BASE_CYCLES = fdf_pkg::FDF_BASE_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic [2:0]         rail_out_of_window_i,
  input  wire logic               clock_source_fault_i,
  input  wire logic [N_CELLS-1:0] cell_ov_i,
  input  wire logic [N_CELLS-1:0] cell_uv_i,
  input  wire logic [N_CELLS-1:0] cell_ot_i,
  input  wire logic [N_CELLS-1:0] cell_ow_i,
  input  wire logic               pack_open_i,
  input  wire logic               gnd_open_i,
  output logic                    alarm_o,
  output logic                    irq_o
);
  import fdf_pkg::*;

  localparam int NF = 2 * N_CELLS + 2;
  localparam int NS = 3 + 1 + 4 * N_CELLS + 2;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers; stage one feeds stage two only
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {gnd_open_i, pack_open_i, cell_ow_i, cell_ot_i, cell_uv_i, cell_ov_i,
                    clock_source_fault_i, rail_out_of_window_i};
      sync2_reg <= sync1_reg;
    end
  end

  logic [2:0]         rail_s;
  logic               clk_s;
  logic [N_CELLS-1:0] ov_s;
  logic [N_CELLS-1:0] uv_s;
  logic [N_CELLS-1:0] ot_s;
  logic [N_CELLS-1:0] ow_s;
  logic               pack_s;
  logic               gnd_s;
  assign rail_s = sync2_reg[2:0];
  assign clk_s  = sync2_reg[3];
  assign ov_s   = sync2_reg[4 +: N_CELLS];
  assign uv_s   = sync2_reg[4+N_CELLS +: N_CELLS];
  assign ot_s   = sync2_reg[4+2*N_CELLS +: N_CELLS];
  assign ow_s   = sync2_reg[4+3*N_CELLS +: N_CELLS];
  assign pack_s = sync2_reg[NS-2];
  assign gnd_s  = sync2_reg[NS-1];

  ////////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after the request, writes at ack edge
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic        wr_en;
  logic        rd_take;
  assign wr_en   = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
  assign rd_take = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end
  end

  logic [31:0] wmask;
  logic [31:0] wdat;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdat  = wb_dat_i & wmask;

  logic wr_setup, wr_status, wr_ov, wr_uv, wr_ot, wr_ow, wr_cmd, wr_iclr, wr_ien;
  assign wr_setup  = wr_en && wb_adr_i == FDF_SETUP_OFS;
  assign wr_status = wr_en && wb_adr_i == FDF_STATUS_OFS;
  assign wr_ov     = wr_en && wb_adr_i == FDF_OV_OFS;
  assign wr_uv     = wr_en && wb_adr_i == FDF_UV_OFS;
  assign wr_ot     = wr_en && wb_adr_i == FDF_OT_OFS;
  assign wr_ow     = wr_en && wb_adr_i == FDF_OW_OFS;
  assign wr_cmd    = wr_en && wb_adr_i == FDF_CMD_OFS;
  assign wr_iclr   = wr_en && wb_adr_i == FDF_IRQ_CLR_OFS;
  assign wr_ien    = wr_en && wb_adr_i == FDF_IRQ_EN_OFS;

  ////////////////////////////////////////////////////////////////////////
  // setup register
  logic [FDF_SETUP_W-1:0] fault_filter_setup_reg;
  logic [2:0]             confirm_count_code;
  logic [3:0]             repeat_period_code;
  assign confirm_count_code = fault_filter_setup_reg[FDF_CONFIRM_LSB +: 3];
  assign repeat_period_code = fault_filter_setup_reg[FDF_PERIOD_LSB +: 4];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_filter_setup_reg <= FDF_SETUP_RST;
    end else if (wr_setup) begin
      fault_filter_setup_reg <= (fault_filter_setup_reg & ~wmask[FDF_SETUP_W-1:0])
                              | wdat[FDF_SETUP_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // scan commands; only these sample the limit results
  logic cont_reg;
  logic vscan_reg, meas_reg, tscan_reg, wscan_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cont_reg <= 1'b0;
    end else if (wr_cmd && wb_sel_i[0]) begin
      cont_reg <= wb_dat_i[FDF_CMD_CONT];
    end
  end

  // interval timer: base ticks of 16 ms, then 2^code base ticks, code clipped at 12
  logic [31:0] pre_cnt_reg;
  logic [12:0] ivl_cnt_reg;
  logic        base_tick;
  logic        ivl_tick;
  logic [3:0]  period_clip;
  logic [12:0] ivl_last;
  assign period_clip = (repeat_period_code > FDF_PERIOD_MAX) ? FDF_PERIOD_MAX
                                                              : repeat_period_code;
  assign ivl_last  = 13'((32'd1 << period_clip) - 32'd1);
  assign base_tick = cont_reg && pre_cnt_reg == 32'(BASE_CYCLES - 1);
  assign ivl_tick  = base_tick && ivl_cnt_reg == ivl_last;

  always_ff @(posedge clk_i) begin
    if (rst_i || !cont_reg) begin
      pre_cnt_reg <= '0;
      ivl_cnt_reg <= '0;
    end else if (base_tick) begin // R12
      pre_cnt_reg <= '0;
      ivl_cnt_reg <= ivl_tick ? 13'h0000 : ivl_cnt_reg + 13'h0001;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 32'h0000_0001;
    end
  end

  // one-cycle sample strobes, one cycle after the command write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vscan_reg <= 1'b0;
      meas_reg  <= 1'b0;
      tscan_reg <= 1'b0;
      wscan_reg <= 1'b0;
    end else begin
      vscan_reg <= (wr_cmd && wb_sel_i[0] && wb_dat_i[FDF_CMD_VSCAN]) || ivl_tick; // R06 R08
      meas_reg  <= wr_cmd && wb_sel_i[0] && wb_dat_i[FDF_CMD_MEASURE]; // R07
      tscan_reg <= (wr_cmd && wb_sel_i[0] && wb_dat_i[FDF_CMD_TSCAN]) || ivl_tick; // R08
      wscan_reg <= (wr_cmd && wb_sel_i[0] && wb_dat_i[FDF_CMD_WSCAN]) || ivl_tick; // R08
    end
  end

  logic cell_sample;
  logic supply_sample;
  assign cell_sample   = vscan_reg | meas_reg; // R05 R07
  assign supply_sample = vscan_reg; // R06

  ////////////////////////////////////////////////////////////////////////
  // confirmation filters: cells ov, cells uv, pack, ground
  logic [NF-1:0] pos;
  logic [NF-1:0] smp;
  logic [NF-1:0] filt_set;
  logic          filt_clr;
  logic [7:0]    target;
  logic [7:0]    cnt_q [NF];
  assign pos    = {gnd_s, pack_s, uv_s, ov_s};
  assign smp    = {supply_sample, supply_sample, {2*N_CELLS{cell_sample}}};
  assign target = 8'(8'h01 << confirm_count_code); // R11

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_filt
      logic [7:0] cnt_reg;
      logic [7:0] cnt_inc;
      assign cnt_inc = cnt_reg + 8'h01;
      assign cnt_q[gi] = cnt_reg;
      // a single counter per input keeps each run independent
      always_ff @(posedge clk_i) begin // R13
        if (rst_i || filt_clr) begin // R15
          cnt_reg <= 8'h00;
        end else if (smp[gi] && !pos[gi]) begin // R14
          cnt_reg <= 8'h00;
        end else if (smp[gi] && cnt_reg < target) begin
          cnt_reg <= cnt_inc;
        end
      end
      assign filt_set[gi] = smp[gi] && pos[gi] && !filt_clr && cnt_inc >= target; // R10
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // per-cell fault bits and status; set wins over a host write
  logic [N_CELLS-1:0] cell_ov_reg, cell_uv_reg, cell_ot_reg, cell_ow_reg;
  logic               pack_reg, gnd_reg, rail_reg, clkf_reg;
  logic [FDF_ST_W-1:0] status;
  logic [FDF_ST_W-1:0] status_prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_ov_reg <= '0;
      cell_uv_reg <= '0;
      cell_ot_reg <= '0;
      cell_ow_reg <= '0;
    end else begin // R18
      cell_ov_reg <= (wr_ov ? wdat[N_CELLS-1:0]
                    : (wr_status && !wdat[FDF_ST_OV]) ? '0 : cell_ov_reg)
                   | filt_set[N_CELLS-1:0]; // R16
      cell_uv_reg <= (wr_uv ? wdat[N_CELLS-1:0]
                    : (wr_status && !wdat[FDF_ST_UV]) ? '0 : cell_uv_reg)
                   | filt_set[2*N_CELLS-1:N_CELLS];
      // temperature and open-wire results are taken as sampled, unfiltered
      cell_ot_reg <= (wr_ot ? wdat[N_CELLS-1:0]
                    : (wr_status && !wdat[FDF_ST_OT]) ? '0 : cell_ot_reg)
                   | (tscan_reg ? ot_s : '0); // R05
      cell_ow_reg <= (wr_ow ? wdat[N_CELLS-1:0]
                    : (wr_status && !wdat[FDF_ST_OW]) ? '0 : cell_ow_reg)
                   | (wscan_reg ? ow_s : '0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pack_reg <= 1'b0;
      gnd_reg  <= 1'b0;
      rail_reg <= 1'b0;
      clkf_reg <= 1'b0;
    end else begin // R04
      pack_reg <= (wr_status ? wdat[FDF_ST_PACK] : pack_reg) | filt_set[NF-2];
      gnd_reg  <= (wr_status ? wdat[FDF_ST_GND]  : gnd_reg)  | filt_set[NF-1];
      rail_reg <= (wr_status ? wdat[FDF_ST_RAIL] : rail_reg) | (|rail_s); // R01
      clkf_reg <= (wr_status ? wdat[FDF_ST_CLK]  : clkf_reg) | clk_s; // R02
    end
  end

  assign status = {clkf_reg, rail_reg, gnd_reg, pack_reg,
                   |cell_ow_reg, |cell_ot_reg, |cell_uv_reg, |cell_ov_reg}; // R03

  // only a host-side change resets the filters, so one validated fault
  // does not restart the count on the others
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_prev_reg <= '0;
    end else begin
      status_prev_reg <= status;
    end
  end

  logic host_wrote_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_wrote_reg <= 1'b0;
    end else begin
      host_wrote_reg <= wr_status | wr_ov | wr_uv | wr_ot | wr_ow;
    end
  end
  assign filt_clr = host_wrote_reg && status != status_prev_reg; // R15

  assign alarm_o = |status; // R17

  ////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write-one clear, enable
  logic [FDF_IRQ_W-1:0] irq_sts_reg, irq_en_reg, irq_evt;
  assign irq_evt = {vscan_reg | meas_reg | tscan_reg | wscan_reg,
                    |filt_set || (|rail_s) || clk_s};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_sts_reg <= '0;
      irq_en_reg  <= '0;
    end else begin
      irq_sts_reg <= (irq_sts_reg & ~(wr_iclr ? wdat[FDF_IRQ_W-1:0] : '0)) | irq_evt;
      if (wr_ien) begin
        irq_en_reg <= wdat[FDF_IRQ_W-1:0];
      end
    end
  end
  assign irq_o = |(irq_sts_reg & irq_en_reg);

  ////////////////////////////////////////////////////////////////////////
  // read mux, unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      case (wb_adr_i)
        FDF_SETUP_OFS:   rdat_reg <= 32'(fault_filter_setup_reg);
        FDF_STATUS_OFS:  rdat_reg <= 32'(status);
        FDF_OV_OFS:      rdat_reg <= 32'(cell_ov_reg);
        FDF_UV_OFS:      rdat_reg <= 32'(cell_uv_reg);
        FDF_OT_OFS:      rdat_reg <= 32'(cell_ot_reg);
        FDF_OW_OFS:      rdat_reg <= 32'(cell_ow_reg);
        FDF_CMD_OFS:     rdat_reg <= 32'(cont_reg) << FDF_CMD_CONT;
        FDF_IRQ_STS_OFS: rdat_reg <= 32'(irq_sts_reg);
        FDF_IRQ_EN_OFS:  rdat_reg <= 32'(irq_en_reg);
        default:         rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_neg_sample;
    cell_sample && !ov_s[0] && !filt_clr;
  endsequence
  sequence s_cnt_zero;
    cnt_q[0] == 8'h00;
  endsequence

  property p_rail;
    @(posedge clk_i) disable iff (rst_i) (|rail_s) |=> status[FDF_ST_RAIL] && alarm_o;
  endproperty
  a_rail: assert property (p_rail) else $error("rail fault not flagged"); // R01
  property p_clk;
    @(posedge clk_i) disable iff (rst_i) clk_s |=> status[FDF_ST_CLK];
  endproperty
  a_clk: assert property (p_clk) else $error("clock fault not flagged"); // R02
  property p_summary;
    @(posedge clk_i) disable iff (rst_i) filt_set[0] |=> status[FDF_ST_OV];
  endproperty
  a_summary: assert property (p_summary) else $error("ov summary missing"); // R03
  property p_scan_only;
    @(posedge clk_i) disable iff (rst_i)
      (cell_ov_reg & ~$past(cell_ov_reg)) != '0 |-> $past(cell_sample) || $past(wr_ov);
  endproperty
  a_scan_only: assert property (p_scan_only) else $error("ov set without scan"); // R05
  property p_cont;
    @(posedge clk_i) disable iff (rst_i) ivl_tick |=> vscan_reg;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous scan missed"); // R08
  property p_code0;
    @(posedge clk_i) disable iff (rst_i)
      supply_sample && pack_s && confirm_count_code == 3'b000 && !filt_clr |=> pack_reg;
  endproperty
  a_code0: assert property (p_code0) else $error("code 0 needs one sample"); // R11
  property p_restart;
    @(posedge clk_i) disable iff (rst_i) s_neg_sample |=> s_cnt_zero;
  endproperty
  a_restart: assert property (p_restart) else $error("filter not restarted"); // R14
  property p_clr_all;
    @(posedge clk_i) disable iff (rst_i) filt_clr |=> s_cnt_zero ##0 cnt_q[NF-1] == 8'h00;
  endproperty
  a_clr_all: assert property (p_clr_all) else $error("filters not cleared"); // R15
  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
      pack_reg && !wr_status |=> pack_reg [*1];
  endproperty
  a_hold: assert property (p_hold) else $error("pack fault dropped"); // R18
  property p_alarm;
    @(posedge clk_i) disable iff (rst_i) (|filt_set) |=> alarm_o;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm missing"); // R17

endmodule
`default_nettype wire

/* sim/fdf_host_model.sv */
// host side model: classic wishbone master that issues register and
// scan command cycles for the fault detection and filtering block.
// assumes the slave answers with a registered one-cycle ack on clk_i.
`timescale 1ns/1ps
`default_nettype none
module fdf_host_model (
  input  wire logic        clk_i,
  input  wire logic        wb_ack_i,
  output logic             wb_cyc_o,
  output logic             wb_stb_o,
  output logic             wb_we_o,
  output logic [7:0]       wb_adr_o,
  output logic [3:0]       wb_sel_o,
  output logic [31:0]      wb_dat_o
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end
  //////////////////////////////////////////////////////////////////////////
  // one bus cycle; scan commands are resent by the caller when repeats
  // are wanted, and status is rewritten by the caller after a fault
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'hF;
    wb_dat_o <= d;
    do @(posedge clk_i); while (wb_ack_i !== 1'b1);
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // released data must not look like the last value
    wb_dat_o <= ~d;
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench of the fault detection and filtering block.
// assumes the host model drives the bus; reads are checked from a queue.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fdf_pkg::*;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [2:0]  rail_i;
  logic        clkf_i, pack_i, gnd_i, alarm_o, irq_o;
  logic [11:0] ov_i, uv_i, ot_i, ow_i, cel;
  logic [31:0] q[$];
  logic [15:0] seed;
  int          num_errors, checked, k, c;

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  fdf_top #(.N_CELLS(12), .BASE_CYCLES(4)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rail_out_of_window_i(rail_i), .clock_source_fault_i(clkf_i),
    .cell_ov_i(ov_i), .cell_uv_i(uv_i), .cell_ot_i(ot_i), .cell_ow_i(ow_i),
    .pack_open_i(pack_i), .gnd_open_i(gnd_i), .alarm_o(alarm_o), .irq_o(irq_o));

  fdf_host_model i_host (
    .clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i),
    .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i), .wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i));

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    i_host.xfer(1'b0, a, 32'h0000_0000);
  endtask
  // three idle cycles let the sample and the filter update land
  task automatic scan(input int b, input int n);
    repeat (n) begin
      wr(FDF_CMD_OFS, 32'h0000_0001 << b);
      cyc(3);
    end
  endtask
  task automatic cmp(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // read data is compared at the ack edge against the oldest note
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      checked++;
      if (q.size() == 0 || wb_dat_o !== q[0]) begin
        num_errors++;
        $display("[ERR] %0t read %h at %h", $time, wb_dat_o, wb_adr_i);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end

  initial begin
    cyc(20000);
    num_errors++;
    complete_run();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    rail_i = 3'b000;
    clkf_i = 1'b0;
    pack_i = 1'b0;
    gnd_i = 1'b0;
    ov_i = '0;
    uv_i = '0;
    ot_i = '0;
    ow_i = '0;
    num_errors = 0;
    checked = 0;
    seed = 16'h824A;
    cyc(3);
    rst_i <= 1'b0;
    rd(FDF_SETUP_OFS, 32'h0000_0000);
    rd(FDF_STATUS_OFS, 32'h0000_0000);
    rd(8'h30, 32'h0000_0000);
    seed = lfsr(seed);
    wr(FDF_SETUP_OFS, {16'h0000, seed});
    rd(FDF_SETUP_OFS, {19'h0_0000, seed[12:0]});
    for (k = 0; k < 4; k++) begin
      if (k < 3) rail_i <= 3'b001 << k;
      else clkf_i <= 1'b1;
      cyc(4);
      cmp(alarm_o, 1'b1);
      rail_i <= 3'b000;
      clkf_i <= 1'b0;
      cyc(4);
      rd(FDF_STATUS_OFS, 32'h0000_0001 << (k < 3 ? FDF_ST_RAIL : FDF_ST_CLK));
      wr(FDF_STATUS_OFS, 32'h0000_0000);
      cyc(2);
      cmp(alarm_o, 1'b0);
    end
    seed = lfsr(seed);
    c = seed % 12;
    // cell 0 always joins, so the cell-0 filter checks see real traffic
    cel = (12'h001 << c) | 12'h001;
    wr(FDF_SETUP_OFS, 32'h0000_0040);
    ov_i <= cel;
    pack_i <= 1'b1;
    cyc(8);
    rd(FDF_STATUS_OFS, 32'h0000_0000);
    scan(FDF_CMD_VSCAN, 3);
    rd(FDF_STATUS_OFS, 32'h0000_0000);
    ov_i <= '0;
    cyc(3);
    scan(FDF_CMD_VSCAN, 1);
    rd(FDF_STATUS_OFS, 32'h0000_0010);
    ov_i <= cel;
    cyc(3);
    scan(FDF_CMD_VSCAN, 3);
    rd(FDF_STATUS_OFS, 32'h0000_0010);
    scan(FDF_CMD_VSCAN, 1);
    rd(FDF_STATUS_OFS, 32'h0000_0011);
    rd(FDF_OV_OFS, {20'h0_0000, cel});
    cmp(alarm_o, 1'b1);
    wr(FDF_STATUS_OFS, 32'h0000_0000);
    scan(FDF_CMD_VSCAN, 3);
    rd(FDF_STATUS_OFS, 32'h0000_0000);
    wr(FDF_SETUP_OFS, 32'h0000_0000);
    ov_i <= '0;
    uv_i <= cel;
    cyc(3);
    scan(FDF_CMD_MEASURE, 1);
    rd(FDF_STATUS_OFS, 32'h0000_0002);
    gnd_i <= 1'b1;
    ot_i <= cel;
    ow_i <= cel;
    cyc(3);
    scan(FDF_CMD_VSCAN, 1);
    rd(FDF_STATUS_OFS, 32'h0000_0032);
    scan(FDF_CMD_TSCAN, 1);
    scan(FDF_CMD_WSCAN, 1);
    rd(FDF_STATUS_OFS, 32'h0000_003E);
    rd(FDF_OW_OFS, {20'h0_0000, cel});
    uv_i <= '0;
    ot_i <= '0;
    ow_i <= '0;
    pack_i <= 1'b0;
    gnd_i <= 1'b0;
    ov_i <= cel;
    wr(FDF_STATUS_OFS, 32'h0000_0000);
    wr(FDF_SETUP_OFS, 32'h0000_0022);
    cyc(3);
    wr(FDF_CMD_OFS, 32'h0000_0001 << FDF_CMD_CONT);
    cyc(8);
    rd(FDF_STATUS_OFS, 32'h0000_0000);
    cyc(40);
    rd(FDF_STATUS_OFS, 32'h0000_0001);
    wr(FDF_CMD_OFS, 32'h0000_0000);
    wr(FDF_IRQ_EN_OFS, 32'h0000_0001);
    wr(FDF_IRQ_CLR_OFS, 32'h0000_0003);
    wr(FDF_STATUS_OFS, 32'h0000_0000);
    cyc(2);
    cmp(irq_o, 1'b0);
    scan(FDF_CMD_VSCAN, 2);
    cmp(irq_o, 1'b1);
    rd(FDF_IRQ_STS_OFS, 32'h0000_0003);
    wr(FDF_IRQ_EN_OFS, 32'h0000_0000);
    cyc(2);
    cmp(irq_o, 1'b0);
    wr(FDF_IRQ_CLR_OFS, 32'h0000_0003);
    rd(FDF_IRQ_STS_OFS, 32'h0000_0000);
    cyc(3);
    complete_run();
  end
endmodule
`default_nettype wire
